// ---- include/dspc_consts.svh ----
// Timing counts and phase-select codes for the dual-slope phase controller.
// Assumes a 100 MHz CLK; counts are derived from times in their own units.
`ifndef DSPC_CONSTS_SVH
`define DSPC_CONSTS_SVH
`define DSPC_CLK_MHZ 100
`define DSPC_CODE_AUTO_ZERO 2'h1
`define DSPC_CODE_INTEGRATE 2'h2
`define DSPC_CODE_DEINTEGRATE 2'h3
`define DSPC_CODE_INT_ZERO 2'h0
`define DSPC_INT_TIME_MS 100
`define DSPC_AZ_TIME_MS 100
`define DSPC_INT_CYCLES (`DSPC_INT_TIME_MS * 1000 * `DSPC_CLK_MHZ)
`define DSPC_AZ_CYCLES (`DSPC_AZ_TIME_MS * 1000 * `DSPC_CLK_MHZ)
`define DSPC_REFERENCE_DEINTEGRATE_PHASE_FACTOR 2
`define DSPC_INTEGRATOR_ZERO_PHASE_TIME_MS 10
`define DSPC_INTEGRATOR_ZERO_PHASE_CYCLES (`DSPC_INTEGRATOR_ZERO_PHASE_TIME_MS * 1000 * `DSPC_CLK_MHZ)
`define DSPC_AVG_LOG2 4
`define DSPC_SYNC_SETTLE 5
`endif

// ---- include/dspc_pkg.sv ----
// Types for the dual-slope phase controller.
// Assumes dspc_consts.svh supplies the numeric constants.
package dspc_pkg;
  typedef enum logic [5:0] {
    DSPC_IDLE = 6'h01,
    DSPC_AZ = 6'h02,
    DSPC_INT = 6'h04,
    DSPC_REFERENCE_DEINTEGRATE_PHASE = 6'h08,
    DSPC_INTEGRATOR_ZERO_PHASE = 6'h10,
    DSPC_DONE = 6'h20
  } dspc_state_t;
endpackage

// ---- rtl/dspc_sync.sv ----
// Three-stage pin synchroniser with agreement-based change detection.
// Assumes an asynchronous pin input on a single clock domain.
`timescale 1ns/100ps
module dspc_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic fell,
  output logic rose
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  wire agree = (s2_q == s3_q);
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        lvl_q <= s3_q;
      end
    end
  end
  assign level = lvl_q;
  assign fell = agree && lvl_q && !s3_q;
  assign rose = agree && !lvl_q && s3_q;
endmodule

// ---- rtl/dspc_ctrl.sv ----
// Conversion controller that sequences a dual-slope front end via two pins.
// Assumes the comparator pin is asynchronous; phase pins drive CMOS inputs.
`timescale 1ns/100ps
`include "dspc_consts.svh"
module dspc_ctrl #(
  parameter int CNT_W = 32,
  parameter int INT_CYCLES = `DSPC_INT_CYCLES,
  parameter int AZ_CYCLES = `DSPC_AZ_CYCLES,
  parameter int REFERENCE_DEINTEGRATE_PHASE_FACTOR = `DSPC_REFERENCE_DEINTEGRATE_PHASE_FACTOR,
  parameter int INTEGRATOR_ZERO_PHASE_CYCLES = `DSPC_INTEGRATOR_ZERO_PHASE_CYCLES,
  parameter int AVG_LOG2 = `DSPC_AVG_LOG2
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic START,
  input wire logic AVG_EN,
  input wire logic COMP_IN,
  output logic PHASE_SEL_A,
  output logic PHASE_SEL_B,
  output logic BUSY,
  output logic DONE,
  output logic SIGN,
  output logic OVER_RANGE,
  output logic INTEGRATOR_ZERO_PHASE_TIMEOUT,
  output logic [CNT_W-1:0] MAGNITUDE,
  output logic AVG_VALID,
  output logic [CNT_W+AVG_LOG2:0] AVG_SUM,
  output logic COMP_LEVEL
);
  localparam logic [CNT_W-1:0] INT_LAST = CNT_W'(INT_CYCLES - 1);
  localparam logic [CNT_W-1:0] AZ_LAST = CNT_W'(AZ_CYCLES - 1);
  localparam logic [CNT_W-1:0] REFERENCE_DEINTEGRATE_PHASE_MAX = CNT_W'(REFERENCE_DEINTEGRATE_PHASE_FACTOR * INT_CYCLES);
  localparam logic [CNT_W-1:0] INTEGRATOR_ZERO_PHASE_LAST = CNT_W'(INTEGRATOR_ZERO_PHASE_CYCLES - 1);
  // Cycles before a level left over from deintegration clears the synchroniser
  localparam logic [CNT_W-1:0] SETTLE = CNT_W'(`DSPC_SYNC_SETTLE);
  localparam int AVG_N = 1 << AVG_LOG2;

  dspc_pkg::dspc_state_t state_q;
  dspc_pkg::dspc_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [1:0] code_q;
  logic sign_q;
  logic over_q;
  logic done_q;
  logic integrator_zero_phase_to_q;
  logic [CNT_W-1:0] mag_q;
  logic [AVG_LOG2:0] avg_cnt_q;
  logic [CNT_W+AVG_LOG2:0] acc_q;
  logic [CNT_W+AVG_LOG2:0] avg_sum_q;
  logic avg_valid_q;
  logic comp_level_q;
  logic busy_q;
  logic comp_lvl;
  logic comp_fell;
  logic comp_rose;

  ////////////////////////////////////////////////////////////////////////////
  dspc_sync u_sync (
    .clk(CLK),
    .rst(RST),
    .pin(COMP_IN),
    .level(comp_lvl),
    .fell(comp_fell),
    .rose(comp_rose)
  );

  ////////////////////////////////////////////////////////////////////////////
  wire in_az = (state_q == dspc_pkg::DSPC_AZ);
  wire in_int = (state_q == dspc_pkg::DSPC_INT);
  wire in_reference_deintegrate_phase = (state_q == dspc_pkg::DSPC_REFERENCE_DEINTEGRATE_PHASE);
  wire in_integrator_zero_phase = (state_q == dspc_pkg::DSPC_INTEGRATOR_ZERO_PHASE);
  wire az_end = in_az && (cnt_q == AZ_LAST);
  wire int_end = in_int && (cnt_q == INT_LAST);
  wire reference_deintegrate_phase_edge = in_reference_deintegrate_phase && comp_fell;
  wire reference_deintegrate_phase_limit = in_reference_deintegrate_phase && !comp_fell && (cnt_q == REFERENCE_DEINTEGRATE_PHASE_MAX);
  wire integrator_zero_phase_high = in_integrator_zero_phase && comp_lvl && (cnt_q >= SETTLE);
  wire integrator_zero_phase_limit = in_integrator_zero_phase && !integrator_zero_phase_high && (cnt_q == INTEGRATOR_ZERO_PHASE_LAST);
  wire cnt_clear = az_end || int_end || reference_deintegrate_phase_edge || reference_deintegrate_phase_limit || (state_d != state_q);
  wire [CNT_W+AVG_LOG2:0] mag_ext = {{(AVG_LOG2+1){1'b0}}, cnt_q};
  wire [CNT_W+AVG_LOG2:0] signed_mag = sign_q ? mag_ext : (~mag_ext + 1'b1);
  wire avg_last = (avg_cnt_q == (AVG_LOG2+1)'(AVG_N - 1));

  function automatic logic [1:0] code_of(input dspc_pkg::dspc_state_t s);
    case (s)
      dspc_pkg::DSPC_INT: code_of = `DSPC_CODE_INTEGRATE;
      dspc_pkg::DSPC_REFERENCE_DEINTEGRATE_PHASE: code_of = `DSPC_CODE_DEINTEGRATE;
      dspc_pkg::DSPC_INTEGRATOR_ZERO_PHASE: code_of = `DSPC_CODE_INT_ZERO;
      default: code_of = `DSPC_CODE_AUTO_ZERO;
    endcase
  endfunction

  always_comb begin
    state_d = state_q;
    case (state_q)
      dspc_pkg::DSPC_IDLE: begin
        if (START) begin
          state_d = dspc_pkg::DSPC_AZ;
        end
      end
      dspc_pkg::DSPC_AZ: begin
        if (az_end) begin
          state_d = dspc_pkg::DSPC_INT;
        end
      end
      dspc_pkg::DSPC_INT: begin
        if (int_end) begin
          state_d = dspc_pkg::DSPC_REFERENCE_DEINTEGRATE_PHASE;
        end
      end
      dspc_pkg::DSPC_REFERENCE_DEINTEGRATE_PHASE: begin
        if (reference_deintegrate_phase_edge || reference_deintegrate_phase_limit) begin
          state_d = dspc_pkg::DSPC_INTEGRATOR_ZERO_PHASE;
        end
      end
      dspc_pkg::DSPC_INTEGRATOR_ZERO_PHASE: begin
        if (integrator_zero_phase_high || integrator_zero_phase_limit) begin
          state_d = dspc_pkg::DSPC_DONE;
        end
      end
      dspc_pkg::DSPC_DONE: begin
        if (START) begin
          state_d = dspc_pkg::DSPC_AZ;
        end
      end
      default: state_d = dspc_pkg::DSPC_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= dspc_pkg::DSPC_IDLE;
      cnt_q <= '0;
      code_q <= `DSPC_CODE_AUTO_ZERO;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_clear ? '0 : cnt_q + 1'b1;
      code_q <= code_of(state_d);
      busy_q <= !((state_d == dspc_pkg::DSPC_IDLE) || (state_d == dspc_pkg::DSPC_DONE));
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      sign_q <= 1'b0;
      over_q <= 1'b0;
      mag_q <= '0;
      done_q <= 1'b0;
      integrator_zero_phase_to_q <= 1'b0;
      comp_level_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      comp_level_q <= comp_lvl;
      if (int_end) begin
        sign_q <= comp_lvl;
      end
      if (reference_deintegrate_phase_edge || reference_deintegrate_phase_limit) begin
        mag_q <= cnt_q;
        over_q <= reference_deintegrate_phase_limit;
      end
      if (integrator_zero_phase_high || integrator_zero_phase_limit) begin
        done_q <= 1'b1;
        integrator_zero_phase_to_q <= integrator_zero_phase_limit;
      end
    end
  end

  // Averaging accumulates signed results over AVG_N conversions
  always_ff @(posedge CLK) begin
    if (RST) begin
      avg_cnt_q <= '0;
      acc_q <= '0;
      avg_sum_q <= '0;
      avg_valid_q <= 1'b0;
    end else begin
      avg_valid_q <= 1'b0;
      if (!AVG_EN) begin
        avg_cnt_q <= '0;
        acc_q <= '0;
      end else if (reference_deintegrate_phase_edge || reference_deintegrate_phase_limit) begin
        if (avg_last) begin
          avg_sum_q <= acc_q + signed_mag;
          avg_valid_q <= 1'b1;
          acc_q <= '0;
          avg_cnt_q <= '0;
        end else begin
          acc_q <= acc_q + signed_mag;
          avg_cnt_q <= avg_cnt_q + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign PHASE_SEL_A = code_q[1];
  assign PHASE_SEL_B = code_q[0];
  assign BUSY = busy_q;
  assign DONE = done_q;
  assign SIGN = sign_q;
  assign OVER_RANGE = over_q;
  assign INTEGRATOR_ZERO_PHASE_TIMEOUT = integrator_zero_phase_to_q;
  assign MAGNITUDE = mag_q;
  assign AVG_VALID = avg_valid_q;
  assign AVG_SUM = avg_sum_q;
  assign COMP_LEVEL = comp_level_q;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_int_ends;
    in_int && cnt_q == INT_LAST;
  endsequence
  property p_int_to_reference_deintegrate_phase;
    @(posedge CLK) disable iff (RST) s_int_ends |=> (code_q == 2'h3) && in_reference_deintegrate_phase;
  endproperty
  a_int_to_reference_deintegrate_phase: assert property (p_int_to_reference_deintegrate_phase) else $error("integrate not followed by deint");
  property p_no_gap;
    @(posedge CLK) disable iff (RST) (code_q == 2'h2) |=> (code_q == 2'h2) || (code_q == 2'h3);
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("gap after integrate");
  property p_sign;
    @(posedge CLK) disable iff (RST) s_int_ends |=> (sign_q == $past(comp_lvl));
  endproperty
  a_sign: assert property (p_sign) else $error("sign not captured");
  property p_mag;
    @(posedge CLK) disable iff (RST) reference_deintegrate_phase_edge |=> (mag_q == $past(cnt_q)) && !over_q && in_integrator_zero_phase;
  endproperty
  a_mag: assert property (p_mag) else $error("magnitude not recorded");
  property p_over;
    @(posedge CLK) disable iff (RST) reference_deintegrate_phase_limit |=> over_q && (code_q == 2'h0);
  endproperty
  a_over: assert property (p_over) else $error("over-range not flagged");
  property p_integrator_zero_phase_hold;
    @(posedge CLK) disable iff (RST) (in_integrator_zero_phase && !comp_lvl && cnt_q != INTEGRATOR_ZERO_PHASE_LAST) |=> in_integrator_zero_phase;
  endproperty
  a_integrator_zero_phase_hold: assert property (p_integrator_zero_phase_hold) else $error("left zero phase early");
  property p_az_after;
    @(posedge CLK) disable iff (RST) integrator_zero_phase_high |=> (code_q == 2'h1) ##1 (code_q == 2'h1);
  endproperty
  a_az_after: assert property (p_az_after) else $error("auto-zero not applied");
  property p_az_ignore;
    @(posedge CLK) disable iff (RST) (in_az && cnt_q != AZ_LAST) |=> in_az;
  endproperty
  a_az_ignore: assert property (p_az_ignore) else $error("comparator acted in auto-zero");
  property p_fell_ends;
    @(posedge CLK) disable iff (RST) reference_deintegrate_phase_edge |=> !in_reference_deintegrate_phase;
  endproperty
  a_fell_ends: assert property (p_fell_ends) else $error("edge did not end deint");
  sequence s_zero_done;
    done_q && !integrator_zero_phase_to_q && (code_q == 2'h1);
  endsequence
  property p_integrator_zero_phase_settle;
    @(posedge CLK) disable iff (RST) (in_integrator_zero_phase && cnt_q < SETTLE) |=> in_integrator_zero_phase;
  endproperty
  a_integrator_zero_phase_settle: assert property (p_integrator_zero_phase_settle) else $error("stale level ended zero phase");
  property p_integrator_zero_phase_exit;
    @(posedge CLK) disable iff (RST) integrator_zero_phase_high |=> s_zero_done;
  endproperty
  a_integrator_zero_phase_exit: assert property (p_integrator_zero_phase_exit) else $error("zero phase end not reported");
  property p_done_idle;
    @(posedge CLK) disable iff (RST) done_q |-> !BUSY && (code_q == 2'h1);
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("not idle in auto-zero at done");
  property p_start_az;
    @(posedge CLK) disable iff (RST)
      (state_q == dspc_pkg::DSPC_IDLE && START) |=> in_az && busy_q && (code_q == 2'h1);
  endproperty
  a_start_az: assert property (p_start_az) else $error("start did not enter auto-zero");
  property p_reference_deintegrate_phase_bound;
    @(posedge CLK) disable iff (RST) in_reference_deintegrate_phase |-> (cnt_q <= REFERENCE_DEINTEGRATE_PHASE_MAX) && (code_q == 2'h3);
  endproperty
  a_reference_deintegrate_phase_bound: assert property (p_reference_deintegrate_phase_bound) else $error("deint count past limit");
  property p_int_len;
    @(posedge CLK) disable iff (RST) (in_int && cnt_q != INT_LAST) |=> in_int && (code_q == 2'h2);
  endproperty
  a_int_len: assert property (p_int_len) else $error("integrate phase cut short");
  property p_sign_hold;
    @(posedge CLK) disable iff (RST) !int_end |=> $stable(sign_q);
  endproperty
  a_sign_hold: assert property (p_sign_hold) else $error("sign changed outside capture");
  property p_avg_valid;
    @(posedge CLK) disable iff (RST) (AVG_EN && avg_last && (reference_deintegrate_phase_edge || reference_deintegrate_phase_limit)) |=> avg_valid_q;
  endproperty
  a_avg_valid: assert property (p_avg_valid) else $error("average not reported");
  property p_comp_level;
    @(posedge CLK) disable iff (RST) 1'b1 |=> (comp_level_q == $past(comp_lvl));
  endproperty
  a_comp_level: assert property (p_comp_level) else $error("comparator level not shown");
endmodule

// ---- test/dspc_frontend_model.sv ----
// Behavioural model of the dual-slope front end: phase pins in, comparator out.
// Assumes the bench sets input polarity and ramp lengths between conversions.
`timescale 1ns/100ps
module dspc_frontend_model (
  input wire logic clk,
  input wire logic phase_sel_a,
  input wire logic phase_sel_b,
  input wire logic input_positive,
  input wire logic [15:0] reference_deintegrate_phase_len,
  input wire logic [15:0] integrator_zero_phase_len,
  output logic comp_out
);
  logic [1:0] code_q = 2'h1;
  logic [15:0] cnt_q = 16'h0;
  logic toggle_q = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // Phase tracking, one cycle behind the pins
  always @(posedge clk) begin
    code_q <= {phase_sel_a, phase_sel_b};
    toggle_q <= ~toggle_q;
    if ({phase_sel_a, phase_sel_b} != code_q) cnt_q <= 16'h0;
    else if (cnt_q != 16'hffff) cnt_q <= cnt_q + 16'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (code_q)
      2'h1: comp_out = toggle_q;
      2'h2: comp_out = input_positive;
      2'h3: comp_out = (cnt_q < reference_deintegrate_phase_len);
      default: comp_out = (cnt_q >= integrator_zero_phase_len);
    endcase
  end
endmodule

// ---- test/dual_slope_phase_control_test.sv ----
// Self-checking bench for the dual-slope phase controller.
// Assumes dspc_frontend_model on the comparator pin and shortened counts.
`timescale 1ns/100ps
module dual_slope_phase_control_test;
  localparam int INT_N = 20;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic start = 1'b0;
  logic avg_en = 1'b0;
  logic pos = 1'b1;
  logic [15:0] dlen = 16'h000a;
  logic [15:0] zlen = 16'h0005;
  logic comp, sel_a, sel_b, busy, done, sign, over, tmo, avg_valid, comp_level;
  logic [31:0] mag;
  logic [36:0] avg_sum;
  int mismatches = 0;
  int comparisons = 0;
  int avg_seen = 0;
  always #5 CLK = ~CLK;
  always @(negedge CLK) if (avg_valid === 1'b1) avg_seen++;
  dspc_ctrl #(.INT_CYCLES(INT_N), .AZ_CYCLES(10), .INTEGRATOR_ZERO_PHASE_CYCLES(30)) DUT (
    .CLK(CLK), .RST(RST), .START(start), .AVG_EN(avg_en), .COMP_IN(comp),
    .PHASE_SEL_A(sel_a), .PHASE_SEL_B(sel_b), .BUSY(busy), .DONE(done), .SIGN(sign),
    .OVER_RANGE(over), .INTEGRATOR_ZERO_PHASE_TIMEOUT(tmo), .MAGNITUDE(mag), .AVG_VALID(avg_valid),
    .AVG_SUM(avg_sum), .COMP_LEVEL(comp_level));
  dspc_frontend_model FE (.clk(CLK), .phase_sel_a(sel_a), .phase_sel_b(sel_b),
    .input_positive(pos), .reference_deintegrate_phase_len(dlen), .integrator_zero_phase_len(zlen), .comp_out(comp));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("%0d mismatches in %0d comparisons", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [1:0] nxt(input logic [1:0] c);
    case (c)
      2'h1: return 2'h2;
      2'h2: return 2'h3;
      2'h3: return 2'h0;
      default: return 2'h1;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // One conversion, phase order and results judged
  task automatic run_conv(input logic p, input logic [15:0] dl, input logic [15:0] zl,
      input logic ov, input logic to);
    logic [1:0] prev;
    logic [1:0] cur;
    logic got;
    int n_int;
    int n_zero;
    pos = p;
    dlen = dl;
    zlen = zl;
    start = 1'b1;
    @(posedge CLK);
    #1 start = 1'b0;
    prev = 2'h1;
    got = 1'b0;
    n_int = 0;
    n_zero = 0;
    for (int n = 0; n < 3000 && !got; n++) begin
      @(posedge CLK);
      #1 cur = {sel_a, sel_b};
      if (cur === 2'h2) n_int++;
      if (cur === 2'h0) n_zero++;
      if (cur !== prev) check(cur, nxt(prev));
      prev = cur;
      got = (done === 1'b1);
      check(busy, !got);
    end
    check(comp_level, !to);
    check(got, 1'b1);
    check(n_int, INT_N);
    check(sign, p);
    check(over, ov);
    check(tmo, to);
    if (!ov) check(mag >= dl && mag <= dl + 6, 1'b1);
    if (!to) check(n_zero >= zl, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge CLK);
    #1 RST = 1'b0;
    check({sel_a, sel_b}, 2'h1);
    check(busy, 1'b0);
    run_conv(1'b1, 16'h000a, 16'h0005, 1'b0, 1'b0);
    run_conv(1'b0, 16'h0011, 16'h0005, 1'b0, 1'b0);
    run_conv(1'b1, 16'hffff, 16'h0005, 1'b1, 1'b0);
    run_conv(1'b0, 16'h000c, 16'hffff, 1'b0, 1'b1);
    avg_en = 1'b1;
    avg_seen = 0;
    repeat (16) run_conv(1'b1, 16'h000a, 16'h0005, 1'b0, 1'b0);
    repeat (3) @(posedge CLK);
    #1 check(avg_seen, 1);
    check(avg_sum >= 160 && avg_sum <= 256, 1'b1);
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    mismatches++;
    tally_and_finish;
  end
endmodule
